// ==== hdl/acc_transfer_decode.sv ====
// Decode and execute of the accumulator transfer instructions
// How it works
// RULE_01: Every instruction here is one word, one instruction cycle, keeps carry and never skips.
// RULE_02: Opcode 252h copies the clock control register into the accumulator unchanged.
// RULE_03: Opcodes 257h and 25Eh copy pull-up control zero and one into the accumulator.
// RULE_04: Opcodes 244h to 246h load the accumulator from converter control one to three.
// RULE_05: Opcode 050h puts the 3-bit stack pointer in the low bits and zero in bit three.
// RULE_06: Opcodes 054h and 055h copy the first and second interrupt control register.
// RULE_07: Six opcodes read timer control one to six, two to six at 24Ch through 250h.
// RULE_08: The page pointer and, at 01Fh, the address pointer are read whole into the accumulator.
// RULE_09: Opcode 053h puts the 2-bit bank pointer in the low bits and zeros above.
// RULE_10: Opcode 00Eh copies the accumulator into register B and keeps the accumulator.
// RULE_11: Opcode 029h loads the 3-bit table pointer from the accumulator's low three bits.
// RULE_12: Opcode 01Ah writes B to the high and the accumulator to the low nibble of E at once.
// RULE_13: Opcodes 228h to 22Ah write the accumulator into port structure control zero to two.
//
// The Avalon-MM slave port and the register offsets were chosen for this implementation.
module acc_transfer_decode #(
  parameter int unsigned INSN_DIV = xfer_pkg::INSN_DIV
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire xfer_pkg::avs_req_t avs_req,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  function automatic xfer_pkg::decode_t decode(input logic [9:0] op);
    xfer_pkg::decode_t d;
    d.kind = xfer_pkg::K_READ;
    d.mask = 4'hf;
    d.slot = 5'h00;
    if (op == xfer_pkg::OP_READ_CLOCK) begin
      d.slot = xfer_pkg::IDX_CLOCK; // RULE_02
    end else if (op == xfer_pkg::OP_READ_PU0) begin
      d.slot = xfer_pkg::IDX_PU0; // RULE_03
    end else if (op == xfer_pkg::OP_READ_PU1) begin
      d.slot = xfer_pkg::IDX_PU1; // RULE_03
    end else if (op >= xfer_pkg::OP_READ_CONV1 &&
                 op <= xfer_pkg::OP_READ_CONV3) begin
      d.slot = 5'(xfer_pkg::IDX_CONV1 + 5'(op - xfer_pkg::OP_READ_CONV1)); // RULE_04
    end else if (op == xfer_pkg::OP_READ_STACK) begin
      d.slot = xfer_pkg::IDX_STACK;
      d.mask = xfer_pkg::MASK_STACK; // RULE_05
    end else if (op == xfer_pkg::OP_READ_V1) begin
      d.slot = xfer_pkg::IDX_V1; // RULE_06
    end else if (op == xfer_pkg::OP_READ_V2) begin
      d.slot = xfer_pkg::IDX_V2; // RULE_06
    end else if (op >= xfer_pkg::OP_READ_TIMER1 &&
                 op <= xfer_pkg::OP_READ_TIMER6) begin
      d.slot = 5'(xfer_pkg::IDX_TIMER1 + 5'(op - xfer_pkg::OP_READ_TIMER1)); // RULE_07
    end else if (op == xfer_pkg::OP_READ_PAGE) begin
      d.slot = xfer_pkg::IDX_PAGE; // RULE_08
    end else if (op == xfer_pkg::OP_READ_ADDRP) begin
      d.slot = xfer_pkg::IDX_ADDRP; // RULE_08
    end else if (op == xfer_pkg::OP_READ_BANK) begin
      d.slot = xfer_pkg::IDX_BANK;
      d.mask = xfer_pkg::MASK_BANK; // RULE_09
    end else if (op == xfer_pkg::OP_ACC_TO_AUX) begin
      d.kind = xfer_pkg::K_TO_AUX;
    end else if (op == xfer_pkg::OP_ACC_TO_TABLE) begin
      d.kind = xfer_pkg::K_TO_TABLE;
      d.slot = xfer_pkg::IDX_TABLE;
      d.mask = xfer_pkg::MASK_TABLE;
    end else if (op == xfer_pkg::OP_LOAD_WIDE) begin
      d.kind = xfer_pkg::K_TO_WIDE;
    end else if (op >= xfer_pkg::OP_WRITE_FR0 &&
                 op <= xfer_pkg::OP_WRITE_FR2) begin
      d.kind = xfer_pkg::K_TO_PORT;
      d.slot = 5'(xfer_pkg::IDX_FR0 + 5'(op - xfer_pkg::OP_WRITE_FR0)); // RULE_13
    end else begin
      d.kind = xfer_pkg::K_NONE;
    end
    return d;
  endfunction : decode

  // Narrow registers keep only their own bits
  function automatic logic [3:0] slot_mask(input logic [4:0] slot);
    logic [3:0] m;
    m = 4'hf;
    if (slot == xfer_pkg::IDX_STACK) begin
      m = xfer_pkg::MASK_STACK;
    end else if (slot == xfer_pkg::IDX_BANK) begin
      m = xfer_pkg::MASK_BANK;
    end else if (slot == xfer_pkg::IDX_TABLE) begin
      m = xfer_pkg::MASK_TABLE;
    end
    return m;
  endfunction : slot_mask

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [xfer_pkg::NFILE-1:0][3:0] file;
    logic [3:0] acc;
    logic [3:0] aux;
    logic carry;
    logic illegal;
    logic [9:0] insn;
    logic [7:0] div;
    xfer_pkg::exec_state_t st;
    logic waitreq;
    logic [31:0] rdata;
  } state_t;

  state_t s_r;
  state_t s_nxt;

  logic req;
  logic in_file;
  logic [4:0] fidx;
  logic tick;
  logic bus_wr;
  logic [3:0] wnib;
  xfer_pkg::decode_t dec;

  assign req = avs_req.read | avs_req.write;
  assign in_file = avs_req.address >= xfer_pkg::ADDR_FILE &&
                   avs_req.address[7:2] <
                   6'(xfer_pkg::ADDR_FILE[7:2] + xfer_pkg::NFILE);
  assign fidx = 5'(avs_req.address[7:2] - xfer_pkg::ADDR_FILE[7:2]);
  assign tick = s_r.div == 8'h00;
  // Write takes effect at the edge where waitrequest is seen low
  assign bus_wr = avs_req.write & ~s_r.waitreq & avs_req.byteenable[0];
  assign wnib = avs_req.writedata[3:0];
  assign dec = decode(s_r.insn);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.div = (s_r.div == 8'(INSN_DIV - 1)) ? 8'h00 : 8'(s_r.div + 8'h01);

    // Bus slave: one idle cycle, more while an instruction is pending, then a single waitrequest-low cycle
    s_nxt.waitreq = 1'b1;
    if (req && s_r.waitreq && s_r.st == xfer_pkg::ST_IDLE) begin
      s_nxt.waitreq = 1'b0;
      s_nxt.rdata = 32'h0000_0000;
      if (avs_req.address == xfer_pkg::ADDR_INSN) begin
        s_nxt.rdata[9:0] = s_r.insn;
      end else if (avs_req.address == xfer_pkg::ADDR_ACC) begin
        s_nxt.rdata[3:0] = s_r.acc;
      end else if (avs_req.address == xfer_pkg::ADDR_AUX) begin
        s_nxt.rdata[3:0] = s_r.aux;
      end else if (avs_req.address == xfer_pkg::ADDR_STAT) begin
        s_nxt.rdata[xfer_pkg::STAT_CARRY] = s_r.carry;
        s_nxt.rdata[xfer_pkg::STAT_ILLEGAL] = s_r.illegal;
      end else if (in_file) begin
        s_nxt.rdata[3:0] = s_r.file[fidx];
      end
    end

    if (bus_wr) begin
      if (avs_req.address == xfer_pkg::ADDR_INSN) begin
        s_nxt.insn = avs_req.writedata[9:0];
        s_nxt.st = xfer_pkg::ST_WAIT;
      end else if (avs_req.address == xfer_pkg::ADDR_ACC) begin
        s_nxt.acc = wnib;
      end else if (avs_req.address == xfer_pkg::ADDR_AUX) begin
        s_nxt.aux = wnib;
      end else if (avs_req.address == xfer_pkg::ADDR_STAT) begin
        s_nxt.carry = wnib[xfer_pkg::STAT_CARRY];
        if (wnib[xfer_pkg::STAT_ILLEGAL]) begin
          s_nxt.illegal = 1'b0;
        end
      end else if (in_file) begin
        s_nxt.file[fidx] = wnib & slot_mask(fidx);
      end
    end

    // Execute on the instruction-cycle enable; carry untouched, no skip
    case (s_r.st)
      xfer_pkg::ST_IDLE: begin
      end
      xfer_pkg::ST_WAIT: begin
        if (tick) begin
          s_nxt.st = xfer_pkg::ST_IDLE; // RULE_01
          case (dec.kind)
            xfer_pkg::K_READ: begin
              s_nxt.acc = s_r.file[dec.slot] & dec.mask; // RULE_05 RULE_09
            end
            xfer_pkg::K_TO_AUX: begin
              s_nxt.aux = s_r.acc; // RULE_10
            end
            xfer_pkg::K_TO_TABLE: begin
              s_nxt.file[dec.slot] = s_r.acc & dec.mask; // RULE_11
            end
            xfer_pkg::K_TO_WIDE: begin
              s_nxt.file[xfer_pkg::IDX_WIDE_HI] = s_r.aux; // RULE_12
              s_nxt.file[xfer_pkg::IDX_WIDE_LO] = s_r.acc; // RULE_12
            end
            xfer_pkg::K_TO_PORT: begin
              s_nxt.file[dec.slot] = s_r.acc; // RULE_13
            end
            default: begin
              s_nxt.illegal = 1'b1;
            end
          endcase
        end
      end
      default: begin
        s_nxt.st = xfer_pkg::ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      s_r.file <= '0;
      s_r.acc <= xfer_pkg::NIB_RESET;
      s_r.aux <= xfer_pkg::NIB_RESET;
      s_r.carry <= 1'b0;
      s_r.illegal <= 1'b0;
      s_r.insn <= 10'h000;
      s_r.div <= 8'h00;
      s_r.st <= xfer_pkg::ST_IDLE;
      s_r.waitreq <= 1'b1;
      s_r.rdata <= 32'h0000_0000;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign avs_readdata = s_r.rdata;
  assign avs_waitrequest = s_r.waitreq;

endmodule : acc_transfer_decode

// ==== shared/xfer_pkg.sv ====
// Constants, types and register map of the accumulator transfer block
package xfer_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned INSN_CYCLE_NS = 30;
  localparam int unsigned INSN_DIV = (INSN_CYCLE_NS * CLK_MHZ + 999) / 1000;

  // ----------------------------------------------------------------
  // Bus register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_INSN = 8'h00;
  localparam logic [7:0] ADDR_ACC = 8'h04;
  localparam logic [7:0] ADDR_AUX = 8'h08;
  localparam logic [7:0] ADDR_STAT = 8'h0c;
  localparam logic [7:0] ADDR_FILE = 8'h10;

  // ----------------------------------------------------------------
  // Register file slots (word index above ADDR_FILE)
  // ----------------------------------------------------------------
  localparam int unsigned NFILE = 24;
  localparam logic [4:0] IDX_CLOCK = 5'h00;
  localparam logic [4:0] IDX_PU0 = 5'h01;
  localparam logic [4:0] IDX_PU1 = 5'h02;
  localparam logic [4:0] IDX_CONV1 = 5'h03;
  localparam logic [4:0] IDX_STACK = 5'h06;
  localparam logic [4:0] IDX_V1 = 5'h07;
  localparam logic [4:0] IDX_V2 = 5'h08;
  localparam logic [4:0] IDX_TIMER1 = 5'h09;
  localparam logic [4:0] IDX_PAGE = 5'h0f;
  localparam logic [4:0] IDX_ADDRP = 5'h10;
  localparam logic [4:0] IDX_BANK = 5'h11;
  localparam logic [4:0] IDX_TABLE = 5'h12;
  localparam logic [4:0] IDX_FR0 = 5'h13;
  localparam logic [4:0] IDX_WIDE_LO = 5'h16;
  localparam logic [4:0] IDX_WIDE_HI = 5'h17;

  // Field masks of the narrow registers
  localparam logic [3:0] MASK_STACK = 4'h7;
  localparam logic [3:0] MASK_BANK = 4'h3;
  localparam logic [3:0] MASK_TABLE = 4'h7;
  localparam logic [3:0] NIB_RESET = 4'h0;

  // Status bit positions
  localparam int unsigned STAT_CARRY = 0;
  localparam int unsigned STAT_SKIP = 1;
  localparam int unsigned STAT_BUSY = 2;
  localparam int unsigned STAT_ILLEGAL = 3;

  // ----------------------------------------------------------------
  // Opcodes
  // ----------------------------------------------------------------
  localparam logic [9:0] OP_READ_CLOCK = 10'h252;
  localparam logic [9:0] OP_READ_PU0 = 10'h257;
  localparam logic [9:0] OP_READ_PU1 = 10'h25e;
  localparam logic [9:0] OP_READ_CONV1 = 10'h244;
  localparam logic [9:0] OP_READ_CONV3 = 10'h246;
  localparam logic [9:0] OP_READ_STACK = 10'h050;
  localparam logic [9:0] OP_READ_V1 = 10'h054;
  localparam logic [9:0] OP_READ_V2 = 10'h055;
  localparam logic [9:0] OP_READ_TIMER1 = 10'h24b;
  localparam logic [9:0] OP_READ_TIMER6 = 10'h250;
  localparam logic [9:0] OP_READ_PAGE = 10'h01e;
  localparam logic [9:0] OP_READ_ADDRP = 10'h01f;
  localparam logic [9:0] OP_READ_BANK = 10'h053;
  localparam logic [9:0] OP_ACC_TO_AUX = 10'h00e;
  localparam logic [9:0] OP_ACC_TO_TABLE = 10'h029;
  localparam logic [9:0] OP_LOAD_WIDE = 10'h01a;
  localparam logic [9:0] OP_WRITE_FR0 = 10'h228;
  localparam logic [9:0] OP_WRITE_FR2 = 10'h22a;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    K_NONE, K_READ, K_TO_AUX, K_TO_TABLE, K_TO_WIDE, K_TO_PORT
  } xfer_kind_t;

  typedef struct packed {
    xfer_kind_t kind;
    logic [4:0] slot;
    logic [3:0] mask;
  } decode_t;

  typedef enum {
    ST_IDLE, ST_WAIT
  } exec_state_t;

  typedef struct packed {
    logic [7:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } avs_req_t;

endpackage : xfer_pkg

// ==== verif/accumulator_transfer_decode_tb.sv ====
// Self-checking testbench of the accumulator transfer block
module accumulator_transfer_decode_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  xfer_pkg::avs_req_t avs_req = '0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  int n_fail = 0;
  int comparisons = 0;
  integer seed = 92428;
  logic [31:0] q;
  logic [3:0] a, b, v;
  // Slot index of each read opcode equals its position
  localparam logic [9:0] RD_OP [18] = '{10'h252, 10'h257, 10'h25e,
    10'h244, 10'h245, 10'h246, 10'h050, 10'h054, 10'h055,
    10'h24b, 10'h24c, 10'h24d, 10'h24e, 10'h24f, 10'h250,
    10'h01e, 10'h01f, 10'h053};

  acc_transfer_decode #(.INSN_DIV(3)) u_acc_transfer_decode (
    .sys_clk(sys_clk), .rstn(rstn), .avs_req(avs_req),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

  initial begin
    forever #5 sys_clk = ~sys_clk;
  end

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task give_verdict;
    if (n_fail == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : give_verdict

  task check(input string what, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check

  // Request held until waitrequest is sampled low
  task bus(input logic wr, input logic [7:0] adr, input logic [31:0] d);
    @(posedge sys_clk);
    avs_req.address <= adr;
    avs_req.read <= !wr;
    avs_req.write <= wr;
    avs_req.writedata <= d;
    avs_req.byteenable <= 4'hf;
    // Only the watchdog ends a wait that never gets an answer
    do begin
      @(posedge sys_clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_req.read <= 1'b0;
    avs_req.write <= 1'b0;
  endtask : bus

  task wr(input logic [7:0] adr, input logic [31:0] d);
    bus(1'b1, adr, d);
  endtask : wr

  task rd(input logic [7:0] adr);
    bus(1'b0, adr, 32'h0);
  endtask : rd

  function automatic logic [7:0] fa(input int i);
    return xfer_pkg::ADDR_FILE + 8'(4 * i);
  endfunction : fa

  function automatic logic [31:0] rd_exp(input int i, input logic [3:0] x);
    logic [3:0] m;
    m = i == int'(xfer_pkg::IDX_STACK) ? xfer_pkg::MASK_STACK :
        i == int'(xfer_pkg::IDX_BANK) ? xfer_pkg::MASK_BANK : 4'hf;
    return {28'h0, x & m};
  endfunction : rd_exp

  // ------------------------------------------------------------
  // Stimulus
  // ------------------------------------------------------------
  initial begin
    repeat (8) @(posedge sys_clk);
    rstn <= 1'b1;
    wr(xfer_pkg::ADDR_STAT, 32'h1);
    rd(8'h80);
    check("unmapped", q, 32'h0);
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 18; i++) begin
        v = p == 0 ? 4'hf : 4'($random(seed));
        wr(fa(i), {28'h0, v});
        wr(xfer_pkg::ADDR_INSN, {22'h0, RD_OP[i]});
        rd(xfer_pkg::ADDR_ACC);
        check("acc", q, rd_exp(i, v));
        rd(fa(i));
        check("source", q, rd_exp(i, v));
      end
    end
    // First pass uses extreme nibbles as corner case
    for (int p = 0; p < 4; p++) begin
      a = p == 0 ? 4'hf : 4'($random(seed));
      b = p == 0 ? 4'h0 : 4'($random(seed));
      wr(xfer_pkg::ADDR_ACC, {28'h0, a});
      wr(xfer_pkg::ADDR_AUX, {28'h0, b});
      wr(xfer_pkg::ADDR_INSN, {22'h0, xfer_pkg::OP_ACC_TO_AUX});
      rd(xfer_pkg::ADDR_AUX);
      check("aux", q, {28'h0, a});
      rd(xfer_pkg::ADDR_ACC);
      check("acc kept", q, {28'h0, a});
      wr(xfer_pkg::ADDR_AUX, {28'h0, b});
      wr(xfer_pkg::ADDR_INSN, {22'h0, xfer_pkg::OP_ACC_TO_TABLE});
      rd(fa(xfer_pkg::IDX_TABLE));
      check("table", q, {28'h0, a & xfer_pkg::MASK_TABLE});
      wr(xfer_pkg::ADDR_INSN, {22'h0, xfer_pkg::OP_LOAD_WIDE});
      rd(fa(xfer_pkg::IDX_WIDE_LO));
      check("wide low", q, {28'h0, a});
      rd(fa(xfer_pkg::IDX_WIDE_HI));
      check("wide high", q, {28'h0, b});
      for (int j = 0; j < 3; j++) begin
        wr(xfer_pkg::ADDR_INSN, {22'h0, xfer_pkg::OP_WRITE_FR0 + 10'(j)});
        rd(fa(xfer_pkg::IDX_FR0 + j));
        check("port struct", q, {28'h0, a});
      end
    end
    // Unknown opcode flags itself, changes nothing, clears on write one
    wr(xfer_pkg::ADDR_INSN, 32'h0000_03ff);
    rd(xfer_pkg::ADDR_STAT);
    check("illegal flag", q, 32'h9);
    rd(xfer_pkg::ADDR_ACC);
    check("acc on unknown", q, {28'h0, a});
    wr(xfer_pkg::ADDR_STAT, 32'h9);
    // Carry kept, no skip, illegal flag cleared
    rd(xfer_pkg::ADDR_STAT);
    check("status", q, 32'h1);
    give_verdict();
  end

  initial begin
    repeat (30000) @(posedge sys_clk);
    n_fail++;
    give_verdict();
  end
endmodule : accumulator_transfer_decode_tb

bind acc_transfer_decode xfer_properties #(.INSN_DIV(INSN_DIV)) u_xfer_properties (
  .sys_clk(sys_clk), .rstn(rstn), .avs_req(avs_req),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

// ==== verif/xfer_properties.sv ====
// Bus-side properties of the accumulator transfer block
module xfer_properties #(
  parameter int unsigned INSN_DIV = 3
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire xfer_pkg::avs_req_t avs_req,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest
);
  timeunit 1ns;
  timeprecision 1ns;
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // Pending instruction may hold the answer for up to INSN_DIV extra cycles
  localparam int ANS_MAX = INSN_DIV + 4;
  localparam logic [7:0] A_STACK = {1'b0, xfer_pkg::IDX_STACK, 2'b00} + 8'h10;
  localparam logic [7:0] A_BANK = {1'b0, xfer_pkg::IDX_BANK, 2'b00} + 8'h10;
  localparam logic [7:0] A_TABLE = {1'b0, xfer_pkg::IDX_TABLE, 2'b00} + 8'h10;
  logic rd_ok;
  assign rd_ok = avs_req.read && !avs_waitrequest;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  a_wait_one_cycle: assert property (
    !avs_waitrequest |=> avs_waitrequest) else $error("answer too long");
  a_answer_in_time: assert property (
    (avs_req.read || avs_req.write) && avs_waitrequest
    |-> ##[1:ANS_MAX] !avs_waitrequest) else $error("answer missing");
  a_no_spurious_answer: assert property (
    !avs_waitrequest |-> (avs_req.read || avs_req.write))
    else $error("answer without request");
  a_skip_never_set: assert property (
    rd_ok && avs_req.address == xfer_pkg::ADDR_STAT |-> !avs_readdata[1])
    else $error("skip flag set");
  a_acc_nibble_only: assert property (
    rd_ok && avs_req.address == xfer_pkg::ADDR_ACC
    |-> avs_readdata[31:4] == 28'h0) else $error("acc wider than nibble");
  a_stack_top_zero: assert property (
    rd_ok && avs_req.address == A_STACK |-> !avs_readdata[3])
    else $error("stack pointer bit three set");
  a_bank_top_zero: assert property (
    rd_ok && avs_req.address == A_BANK |-> avs_readdata[3:2] == 2'b00)
    else $error("bank pointer upper bits set");
  a_table_top_zero: assert property (
    rd_ok && avs_req.address == A_TABLE |-> !avs_readdata[3])
    else $error("table pointer bit three set");
  a_upper_bits_zero: assert property (
    rd_ok |-> avs_readdata[31:10] == 22'h0) else $error("upper bits set");

  c_read_done: cover property (rd_ok);
  c_write_done: cover property (avs_req.write && !avs_waitrequest);
  c_status_read: cover property (rd_ok && avs_req.address == 8'h0c);
endmodule : xfer_properties
